//--- rtl/sqs_consts.vh
/*
 Constants of the serial quad slave command front end: instruction codes,
 last unit indices of each transfer phase, and address stepping codes.
 Assumes inclusion by the design files and the testbench of this block only.
*/
`ifndef SQS_CONSTS_VH
`define SQS_CONSTS_VH

// Instruction codes.
`define SQS_OP_ENTER_QUAD  8'h38
`define SQS_OP_EXIT_QUAD   8'hff
`define SQS_OP_READ        8'h03
`define SQS_OP_FAST_READ   8'h0b
`define SQS_OP_DUAL_READ   8'h3b

// Last unit index of each phase (units counted from zero).
`define SQS_CMD_LAST_1     5'h07
`define SQS_CMD_LAST_4     5'h01
`define SQS_ADDR_LAST_1    5'h0f
`define SQS_ADDR_LAST_4    5'h03
`define SQS_DUMMY_LAST_1   5'h07
`define SQS_DUMMY_LAST_4   5'h05
`define SQS_DATA_LAST_1    5'h1f
`define SQS_DATA_LAST_2    5'h0f
`define SQS_DATA_LAST_4    5'h07

// Address bits 15:14 stepping codes, and the DWORD step in bytes.
`define SQS_STEP_INC       2'h1
`define SQS_STEP_DEC       2'h2
`define SQS_DWORD_BYTES    14'h0004

// Reset values.
`define SQS_RST_QUAD       1'h0
`define SQS_RST_OE_N       4'hf

`endif

//--- rtl/sqs_sync2.v
/*
 Two flip-flop synchroniser for a group of independent level inputs.
 Assumes each bit is a level from outside the clk_sys domain.
*/
`timescale 1ns/1ns
module sqs_sync2 #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  // Levels
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // sqs_sync2

//--- rtl/sqs_buf2.v
/*
 Two-entry buffer with valid and ready on both sides and a flush.
 Assumes both sides run on clk_sys; in_ready comes from a flip-flop.
*/
`timescale 1ns/1ns
module sqs_buf2 #(
  parameter W = 46
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire         flush,
  // Filling side
  input  wire         in_valid,
  output reg          in_ready,
  input  wire [W-1:0] in_data,
  // Draining side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem [0:1];
  reg         wptr;
  reg         rptr;
  reg [1:0]   cnt;
  wire        push;
  wire        pop;
  reg  [1:0]  next_cnt;

  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @* begin
    next_cnt = cnt;
    if (push & ~pop)
      next_cnt = cnt + 2'h1;
    else if (pop & ~push)
      next_cnt = cnt - 2'h1;
  end

  always @(posedge clk_sys) begin
    if (push)
      mem[wptr] <= in_data;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wptr     <= 1'b0;
      rptr     <= 1'b0;
      cnt      <= 2'h0;
      in_ready <= 1'b1;
    end else if (flush) begin
      wptr     <= 1'b0;
      rptr     <= 1'b0;
      cnt      <= 2'h0;
      in_ready <= 1'b1;
    end else begin
      if (push)
        wptr <= ~wptr;
      if (pop)
        rptr <= ~rptr;
      cnt      <= next_cnt;
      in_ready <= (next_cnt != 2'h2);
    end
  end

endmodule // sqs_buf2

//--- rtl/sqs_serial_slave.v
/*
 Serial quad slave command front end: decodes single-lane, dual-output and
 quad-mode read commands from an external serial master, steps the DWORD
 address, and shifts register snapshots out on one, two or four lanes.
 Assumes: serial clock, select and lanes are asynchronous and are sampled by
 clk_sys (at least eight clk_sys periods per serial clock period); the
 register side answers rd_req with rd_valid within two clk_sys cycles and
 applies read side effects, deferring live-bit events, on rd_ind.
*/
// Behaviour
// - In quad mode only exit-quad and fast read; all units four bits.
// - Before initialization completes, pins are ignored and change nothing.
// - After initialization, pins stay ignored until select rises once.
// - Read data before initialization completes is not valid.
// - Outside full power, reads and pin activity are ignored.
// - Back at full power, pins stay ignored until select rises.
// - Code 38h on lane 0 in single-lane mode enters quad mode.
// - Code FFh leaves quad mode, serial or as nibbles.
// - Continued clocking reads more words; bits 15:14 step address.
// - Bits 13:0 of the two address bytes form a byte address.
// - Each 32-bit word is captured as a snapshot before shifting.
// - Read side effects happen when shifting starts, even if aborted.
// - Live-bit events after the snapshot are deferred past read indication.
// - Plain read 03h drives lane 1 after the last address bit.
// - Releasing select floats all data outputs at once.
// - Single-lane fast read has one dummy byte, then one bit per edge.
// - Quad fast read has three dummy bytes, then nibbles on four lanes.
// - Dual-output read 3Bh sends bit pairs on lanes 1:0.
// - Inputs sampled on rising edge, outputs change on falling edge.
// - Commands and address msb first; data LSB first, byte msb first.
// - Lanes stay undriven during dummy cycles.
`timescale 1ns/1ns
`include "sqs_consts.vh"
module sqs_serial_slave #(
  parameter AW = 14,
  parameter DW = 32
) (
  // Clock and reset
  input  wire          clk_sys,
  input  wire          rst_n,
  // Serial link
  input  wire          serial_clk,
  input  wire          serial_select_n,
  input  wire [3:0]    serial_io_lanes_in,
  output reg  [3:0]    serial_io_lanes_out,
  output reg  [3:0]    serial_io_lanes_oe_n,
  // Device state
  input  wire          init_done,
  input  wire          full_power_state,
  // Register read port
  output reg           rd_req,
  output reg  [AW-1:0] rd_addr,
  input  wire [DW-1:0] rd_data,
  input  wire          rd_valid,
  output wire          rd_ready,
  output reg           rd_ind,
  output reg  [AW-1:0] rd_ind_addr,
  // Status
  output reg           quad_lane_mode
);

  localparam ST_IDLE   = 6'h01;
  localparam ST_CMD    = 6'h02;
  localparam ST_ADDR   = 6'h04;
  localparam ST_DUMMY  = 6'h08;
  localparam ST_DATA   = 6'h10;
  localparam ST_IGNORE = 6'h20;

  wire [5:0]    sync_q;
  reg           sck_d;
  reg           cs_d;
  reg           armed;
  reg  [5:0]    state;
  reg  [4:0]    cnt;
  reg  [4:0]    dummy_last;
  reg           has_dummy;
  reg  [2:0]    lane_w;
  reg  [15:0]   shift;
  reg  [1:0]    step;
  reg  [DW-1:0] obuf;
  reg           have_word;
  reg  [15:0]   next_shift;
  reg  [DW-1:0] next_obuf;
  reg  [4:0]    cnt_last;
  wire          s_sck;
  wire          s_cs_n;
  wire [3:0]    s_io;
  wire          rise;
  wire          fall;
  wire          sel;
  wire          pop;
  wire          buf_valid;
  wire [AW+DW-1:0] buf_data;
  wire [7:0]    op;

  sqs_sync2 #(
    .W (6)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({serial_clk, ~serial_select_n, serial_io_lanes_in}),
    .q       (sync_q)
  );

  assign s_sck  = sync_q[5];
  // Select is synchronised inverted so that reset leaves it at its idle high level.
  // Otherwise the first clocks after reset would see a false select rise and arm.
  assign s_cs_n = ~sync_q[4];
  assign s_io   = sync_q[3:0];
  assign rise   = s_sck & ~sck_d;
  assign fall   = ~s_sck & sck_d;

  assign sel = armed & ~s_cs_n & init_done & full_power_state;

  assign pop = sel & (state == ST_DATA) & fall & (cnt == 5'h00);

  sqs_buf2 #(
    .W (AW + DW)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .flush     (~sel),
    .in_valid  (rd_valid),
    .in_ready  (rd_ready),
    .in_data   ({rd_addr, rd_data}),
    .out_valid (buf_valid),
    .out_ready (pop),
    .out_data  (buf_data)
  );

  function [DW-1:0] lsb_first;
    input [DW-1:0] w;
    begin
      lsb_first = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
  endfunction

  assign op = next_shift[7:0];

  always @* begin
    if (quad_lane_mode)
      next_shift = {shift[11:0], s_io};
    else
      next_shift = {shift[14:0], s_io[0]};
    if (cnt != 5'h00)
      next_obuf = obuf << lane_w;
    else if (buf_valid)
      next_obuf = lsb_first(buf_data[DW-1:0]);
    else
      next_obuf = {DW{1'b0}};
    case (state)
      ST_CMD:   cnt_last = quad_lane_mode ? `SQS_CMD_LAST_4 : `SQS_CMD_LAST_1;
      ST_ADDR:  cnt_last = quad_lane_mode ? `SQS_ADDR_LAST_4 : `SQS_ADDR_LAST_1;
      ST_DUMMY: cnt_last = dummy_last;
      ST_DATA:  cnt_last = (lane_w == 3'h4) ? `SQS_DATA_LAST_4 :
                           (lane_w == 3'h2) ? `SQS_DATA_LAST_2 : `SQS_DATA_LAST_1;
      default:  cnt_last = 5'h00;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
      armed <= 1'b0;
    end else begin
      sck_d <= s_sck;
      cs_d  <= s_cs_n;
      if (!init_done || !full_power_state)
        armed <= 1'b0;
      else if (s_cs_n & ~cs_d)
        armed <= 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state                <= ST_IDLE;
      cnt                  <= 5'h00;
      dummy_last           <= 5'h00;
      has_dummy            <= 1'b0;
      lane_w               <= 3'h1;
      shift                <= 16'h0000;
      step                 <= 2'h0;
      obuf                 <= {DW{1'b0}};
      have_word            <= 1'b0;
      quad_lane_mode       <= `SQS_RST_QUAD;
      serial_io_lanes_out  <= 4'h0;
      serial_io_lanes_oe_n <= `SQS_RST_OE_N;
      rd_req               <= 1'b0;
      rd_addr              <= {AW{1'b0}};
      rd_ind               <= 1'b0;
      rd_ind_addr          <= {AW{1'b0}};
    end else begin
      rd_req <= 1'b0;
      rd_ind <= 1'b0;
      if (!sel) begin
        state                <= ST_IDLE;
        cnt                  <= 5'h00;
        have_word            <= 1'b0;
        serial_io_lanes_oe_n <= `SQS_RST_OE_N;
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_CMD;
            cnt   <= 5'h00;
          end
          ST_CMD: begin
            if (rise) begin
              shift <= next_shift;
              cnt   <= cnt + 5'h01;
              if (cnt == cnt_last) begin
                cnt   <= 5'h00;
                state <= ST_IGNORE;
                if (quad_lane_mode) begin
                  if (op == `SQS_OP_EXIT_QUAD) begin
                    quad_lane_mode <= 1'b0;
                  end else if (op == `SQS_OP_FAST_READ) begin
                    lane_w     <= 3'h4;
                    has_dummy  <= 1'b1;
                    dummy_last <= `SQS_DUMMY_LAST_4;
                    state      <= ST_ADDR;
                  end
                end else begin
                  case (op)
                    `SQS_OP_ENTER_QUAD: quad_lane_mode <= 1'b1;
                    `SQS_OP_EXIT_QUAD: quad_lane_mode <= 1'b0;
                    `SQS_OP_READ: begin
                      lane_w    <= 3'h1;
                      has_dummy <= 1'b0;
                      state     <= ST_ADDR;
                    end
                    `SQS_OP_FAST_READ: begin
                      lane_w     <= 3'h1;
                      has_dummy  <= 1'b1;
                      dummy_last <= `SQS_DUMMY_LAST_1;
                      state      <= ST_ADDR;
                    end
                    `SQS_OP_DUAL_READ: begin
                      lane_w     <= 3'h2;
                      has_dummy  <= 1'b1;
                      dummy_last <= `SQS_DUMMY_LAST_1;
                      state      <= ST_ADDR;
                    end
                    default: state <= ST_IGNORE;
                  endcase
                end
              end
            end
          end
          ST_ADDR: begin
            if (rise) begin
              shift <= next_shift;
              cnt   <= cnt + 5'h01;
              if (cnt == cnt_last) begin
                cnt     <= 5'h00;
                rd_addr <= next_shift[AW-1:0];
                step    <= next_shift[15:14];
                rd_req  <= 1'b1;
                state   <= has_dummy ? ST_DUMMY : ST_DATA;
              end
            end
          end
          ST_DUMMY: begin
            serial_io_lanes_oe_n <= `SQS_RST_OE_N;
            if (rise) begin
              cnt <= cnt + 5'h01;
              if (cnt == cnt_last) begin
                cnt   <= 5'h00;
                state <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (fall) begin
              obuf      <= next_obuf;
              have_word <= 1'b1;
              cnt       <= (cnt == cnt_last) ? 5'h00 : cnt + 5'h01;
              if (lane_w == 3'h4) begin
                serial_io_lanes_out  <= next_obuf[DW-1:DW-4];
                serial_io_lanes_oe_n <= 4'h0;
              end else if (lane_w == 3'h2) begin
                serial_io_lanes_out  <= {2'h0, next_obuf[DW-1:DW-2]};
                serial_io_lanes_oe_n <= 4'hc;
              end else begin
                serial_io_lanes_out  <= {2'h0, next_obuf[DW-1], 1'b0};
                serial_io_lanes_oe_n <= 4'hd;
              end
              if (cnt == 5'h00) begin
                rd_ind      <= buf_valid;
                rd_ind_addr <= buf_data[AW+DW-1:DW];
              end
            end else if (rise && cnt == 5'h00 && have_word) begin
              rd_req <= 1'b1;
              if (step == `SQS_STEP_INC)
                rd_addr <= rd_addr + `SQS_DWORD_BYTES;
              else if (step == `SQS_STEP_DEC)
                rd_addr <= rd_addr - `SQS_DWORD_BYTES;
            end
          end
          ST_IGNORE: begin
            serial_io_lanes_oe_n <= `SQS_RST_OE_N;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // sqs_serial_slave

//--- verification/sqs_host_model.sv
/*
 Serial master model: makes the serial clock, select and lane levels.
 Assumes clk_sys runs eight times faster than the serial clock it makes.
*/
`timescale 1ns/1ns
module sqs_host_model (
  // Clock
  input  wire       clk_sys,
  // Serial link
  output reg        serial_clk,
  output reg        serial_select_n,
  output wire [3:0] serial_io_lanes_in,
  input  wire [3:0] serial_io_lanes_out,
  input  wire [3:0] serial_io_lanes_oe_n
);
  reg [3:0] drv;
  reg       hold;
  // Released lanes show the last value while sending and its inverse otherwise, so stale data never matches.
  assign serial_io_lanes_in = ~serial_io_lanes_oe_n & serial_io_lanes_out |
                              serial_io_lanes_oe_n & (hold ? drv : ~drv);
  initial begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    drv = 4'h0;
    hold = 1'b0;
  end
  task wt;
    repeat (4) @(negedge clk_sys);
  endtask
  task unit(input [3:0] d, input bit h, output [3:0] s);
    drv = d;
    hold = h;
    wt;
    serial_clk = 1'b1;
    wt;
    s = serial_io_lanes_in;
    serial_clk = 1'b0;
  endtask
  task send(input [31:0] v, input int n, input int w);
    reg [3:0] s;
    for (int i = n - 1; i >= 0; i--)
      unit(4'((v >> (i * w)) & ((32'h1 << w) - 1)), 1'b1, s);
  endtask
  task get(input int n, input int w, output [31:0] v);
    reg [3:0] s;
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      unit(drv, 1'b0, s);
      v = (v << w) | (w == 1 ? {3'h0, s[1]} : w == 2 ? {2'h0, s[1:0]} : s);
    end
  endtask
  task sel(input bit n);
    wt;
    serial_select_n = n;
    hold = 1'b0;
    wt;
  endtask
endmodule // sqs_host_model

//--- verification/sqs_serial_slave_chk.sv
/*
 Checker of the serial slave's port behaviour.
 Assumes it is bound to sqs_serial_slave and serial clock halves of 4 clk_sys.
*/
`timescale 1ns/1ns
module sqs_serial_slave_chk #(
  parameter AW = 14,
  parameter DW = 32
) (
  // Clock and reset
  input wire          clk_sys,
  input wire          rst_n,
  // Serial link
  input wire          serial_clk,
  input wire          serial_select_n,
  input wire [3:0]    serial_io_lanes_out,
  input wire [3:0]    serial_io_lanes_oe_n,
  // Device state
  input wire          init_done,
  input wire          full_power_state,
  // Register read port
  input wire          rd_req,
  input wire [AW-1:0] rd_addr,
  input wire          rd_ind,
  input wire [AW-1:0] rd_ind_addr,
  input wire          quad_lane_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_float_idle: assert property (serial_select_n [*4] |-> serial_io_lanes_oe_n == 4'hf)
    else $error("lanes driven while deselected");
  chk_init_quiet: assert property (!init_done [*3] |-> !rd_req && !rd_ind)
    else $error("read activity before init");
  chk_power_quiet: assert property (!full_power_state [*3] |-> !rd_req && !rd_ind)
    else $error("read activity in low power");
  chk_ind_pair: assert property (rd_ind |-> rd_ind_addr == rd_addr)
    else $error("indication address differs");
  chk_req_spacing: assert property (rd_req |=> !rd_req [*8])
    else $error("requests too close");
  chk_quad_width: assert property (quad_lane_mode && serial_io_lanes_oe_n != 4'hf
    |-> serial_io_lanes_oe_n == 4'h0)
    else $error("quad output not four lanes");
  chk_single_width: assert property (!quad_lane_mode |->
    serial_io_lanes_oe_n inside {4'hf, 4'hd, 4'hc})
    else $error("bad lane enables");
  chk_rise_stable: assert property ($rose(serial_clk) |-> ##2 $stable(serial_io_lanes_out) [*4])
    else $error("output changed after rising edge");
  chk_mode_hold: assert property (serial_select_n [*4] |=> $stable(quad_lane_mode))
    else $error("mode changed while deselected");
endmodule // sqs_serial_slave_chk

//--- verification/test_sqs_serial_slave.sv
/*
 Self-checking bench of the serial slave with a host model and register side.
 Assumes the design files and sqs_consts.vh are on the include path.
*/
`timescale 1ns/1ns
`include "sqs_consts.vh"
module test_sqs_serial_slave;
  localparam AW = 14;
  localparam DW = 32;
  reg           clk_sys, rst_n, init_done, full_power_state, rd_valid, took;
  reg  [DW-1:0] rd_data, salt;
  wire          serial_clk, serial_select_n, rd_req, rd_ready, rd_ind, quad_lane_mode;
  wire [3:0]    lanes_in, lanes_out, oe_n;
  wire [AW-1:0] rd_addr, rd_ind_addr;
  integer       mismatches, total_checks, reqs, inds, drives, cycles, i0;
  sqs_serial_slave #(.AW(AW), .DW(DW)) sqs_serial_slave_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_io_lanes_in(lanes_in),
    .serial_io_lanes_out(lanes_out), .serial_io_lanes_oe_n(oe_n),
    .init_done(init_done), .full_power_state(full_power_state), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_ind(rd_ind), .rd_ind_addr(rd_ind_addr), .quad_lane_mode(quad_lane_mode));
  sqs_host_model sqs_host_model_i (
    .clk_sys(clk_sys), .serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_io_lanes_in(lanes_in), .serial_io_lanes_out(lanes_out),
    .serial_io_lanes_oe_n(oe_n));
  function [31:0] word(input [13:0] a);
    word = {a, 2'h2, ~a, 2'h1} ^ salt;
  endfunction
  function [13:0] step(input [13:0] a, input [1:0] m);
    step = m == 2'h1 ? a + 14'h0004 : m == 2'h2 ? a - 14'h0004 : a;
  endfunction
  // Low byte goes out first, so the shifted stream reads as the byte-swapped word.
  function [31:0] swap_bytes(input [31:0] x);
    swap_bytes = {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  task end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input string what, input [31:0] exp, input [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The register side answers on the falling edge, half a cycle after each request.
  always @(negedge clk_sys) begin
    if (took) rd_valid <= 1'b0;
    if (rd_req) begin
      rd_valid <= 1'b1;
      rd_data <= word(rd_addr);
    end
  end
  always @(posedge clk_sys) begin
    took <= rd_valid & rd_ready;
    reqs <= reqs + rd_req;
    inds <= inds + rd_ind;
    drives <= drives + (oe_n != 4'hf);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  task xfer(input [7:0] op, input [1:0] m, input int cw, input int dn, input int dw,
            input int nw, input int cut);
    reg [31:0] v;
    reg [13:0] a;
    a = 14'($urandom);
    sqs_host_model_i.sel(1'b0);
    sqs_host_model_i.send({24'h0, op}, 8 / cw, cw);
    sqs_host_model_i.send({16'h0, m, a}, 16 / cw, cw);
    sqs_host_model_i.send(32'h0, dn, cw);
    for (int k = 0; k < nw; k++) begin
      sqs_host_model_i.get(cut > 0 ? cut : 32 / dw, dw, v);
      if (cut == 0) check("data", swap_bytes(word(a)), v);
      a = step(a, m);
    end
    sqs_host_model_i.sel(1'b1);
    check("ready", 32'h1, rd_ready);
  endtask
  task quiet(input [7:0] op, input int cw);
    integer r, d;
    r = reqs;
    d = drives;
    xfer(op, 2'h0, cw, 0, 1, 0, 0);
    check("requests", r, reqs);
    check("drives", d, drives);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    rst_n = 1'b0;
    init_done = 1'b0;
    full_power_state = 1'b1;
    rd_valid = 1'b0;
    rd_data = 32'h0;
    {mismatches, total_checks, reqs, inds, drives, cycles} = 0;
    void'($urandom(59));
    salt = $urandom;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    quiet(`SQS_OP_FAST_READ, 1);
    init_done = 1'b1;
    quiet(`SQS_OP_FAST_READ, 1);
    xfer(`SQS_OP_READ, 2'h0, 1, 0, 1, 1, 0);
    for (int k = 0; k < 6; k++)
      xfer(k % 3 == 0 ? `SQS_OP_READ : k % 3 == 1 ? `SQS_OP_FAST_READ : `SQS_OP_DUAL_READ,
           2'(k), 1, k % 3 == 0 ? 0 : 8, k % 3 == 2 ? 2 : 1, 2, 0);
    i0 = inds;
    xfer(`SQS_OP_READ, 2'h1, 1, 0, 1, 1, 4);
    check("indications", i0 + 1, inds);
    quiet(8'h5a, 1);
    quiet(`SQS_OP_ENTER_QUAD, 1);
    check("quad", 32'h1, quad_lane_mode);
    quiet(`SQS_OP_READ, 4);
    xfer(`SQS_OP_FAST_READ, 2'h1, 4, 6, 4, 2, 0);
    quiet(`SQS_OP_EXIT_QUAD, 4);
    check("quad", 32'h0, quad_lane_mode);
    quiet(`SQS_OP_EXIT_QUAD, 1);
    check("quad", 32'h0, quad_lane_mode);
    full_power_state = 1'b0;
    quiet(`SQS_OP_READ, 1);
    full_power_state = 1'b1;
    quiet(`SQS_OP_READ, 1);
    xfer(`SQS_OP_READ, 2'h2, 1, 0, 1, 2, 0);
    end_sim;
  end
endmodule // test_sqs_serial_slave
bind sqs_serial_slave sqs_serial_slave_chk #(.AW(AW), .DW(DW)) chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk),
  .serial_select_n(serial_select_n), .serial_io_lanes_out(serial_io_lanes_out),
  .serial_io_lanes_oe_n(serial_io_lanes_oe_n), .init_done(init_done),
  .full_power_state(full_power_state), .rd_req(rd_req), .rd_addr(rd_addr),
  .rd_ind(rd_ind), .rd_ind_addr(rd_ind_addr), .quad_lane_mode(quad_lane_mode));
